// ---- pkg/fid_pkg.sv ----
// Shared constants, types and the residency accumulate step for the
// forced idle duty cycling block.
// Assumes one clock domain and model register addresses of 12 bits.
package fid_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Model register addresses.
    localparam logic [11:0] ADDR_PKG_ENABLE = 12'hDB0;
    localparam logic [11:0] ADDR_THREAD_ALLOW = 12'hDB1;
    localparam logic [11:0] ADDR_THREAD_STALL = 12'hDB2;
    localparam logic [11:0] ADDR_CORE_IDLE = 12'h653;
    localparam logic [11:0] ADDR_PKG_SHALLOW = 12'h655;
    localparam logic [11:0] ADDR_PKG_DEEP = 12'h656;
    localparam logic [11:0] ADDR_DEEP_CONFIG = 12'h652;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int ENABLE_BIT = 0;
    localparam int ALLOW_BIT = 0;
    localparam int SELECT_LSB = 0;
    localparam int SELECT_W = 3;
    localparam logic RST_PKG_ENABLE = 1'h0;
    localparam logic RST_THREAD_ALLOW = 1'h1;
    localparam logic [2:0] RST_DEEP_SELECT = 3'h0;
    localparam logic [63:0] RST_COUNTER = 64'h0;

    ////////////////////////////////////////////////////////////////////////
    // Package C-state level input and deep select codes share one order.
    localparam logic [2:0] PKG_C0 = 3'h0;
    localparam logic [2:0] PKG_C2 = 3'h1;
    localparam logic [2:0] PKG_C3 = 3'h2;
    localparam logic [2:0] PKG_C6 = 3'h3;
    localparam logic [2:0] PKG_C7 = 3'h4;
    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_C2_ONLY = 3'h1;
    localparam logic [2:0] SEL_LAST = 3'h4;

    // Thread C-state request codes.
    localparam logic [2:0] CST_C0 = 3'h0;
    localparam logic [2:0] CST_C3 = 3'h3;

    // Default propagation delay of the package enable, in cycles.
    localparam int PROP_CYCLES_DEF = 64;
    localparam int TICK_DIV_DEF = 1;

    ////////////////////////////////////////////////////////////////////////
    // Residency accumulator: pending interval and visible count.
    typedef struct packed {
        logic on;
        logic [63:0] pend;
        logic [63:0] cnt;
    } fid_acc_s;

    // Counts ticks while the condition holds, folds them in on exit.
    function automatic fid_acc_s fid_acc_step(input fid_acc_s a,
                                              input logic cond,
                                              input logic tick);
        fid_acc_s r;
        r = a;
        if (cond) begin
            r.on = 1'b1;
            if (tick) begin
                r.pend = a.pend + 64'h1;
            end
        end else begin
            if (a.on) begin
                r.cnt = a.cnt + a.pend;
            end
            r.pend = 64'h0;
            r.on = 1'b0;
        end
        return r;
    endfunction : fid_acc_step

endpackage : fid_pkg

// ---- core/fid_thread.sv ----
// One logical processor: allow bit, forced idle state and stall counter.
// Assumes the parent gates allow writes by capability and thread index.
`timescale 1ns/1ps
`default_nettype none

module fid_thread (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stampTick,
    input wire logic allowWr,
    input wire logic allowWdata,
    input wire logic enableArrived,
    input wire logic dutyPhase,
    input wire logic holdOff,
    input wire logic threadActive,
    output logic allowBit,
    output logic forcedIdle,
    output logic refCountEn,
    output logic actCountEn,
    output logic [2:0] cstateReq,
    output logic [63:0] stallCount
);

    typedef struct packed {
        logic allow;
        logic forced;
        logic refEn;
        logic actEn;
        logic [2:0] cst;
        fid_pkg::fid_acc_s acc;
    } fid_thread_s;

    fid_thread_s s;
    fid_thread_s n;

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        n = s;
        if (allowWr) begin
            n.allow = allowWdata;
        end
        // The latest completed allow value is used whenever enable arrives.
        n.forced = enableArrived & s.allow & dutyPhase & ~holdOff;
        n.refEn = threadActive | n.forced;
        n.actEn = threadActive & ~n.forced;
        n.cst = n.forced ? fid_pkg::CST_C3 : fid_pkg::CST_C0;
        n.acc = fid_pkg::fid_acc_step(s.acc, s.forced, stampTick);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.allow <= fid_pkg::RST_THREAD_ALLOW;
        end else begin
            s <= n;
        end
    end

    assign allowBit = s.allow;
    assign forcedIdle = s.forced;
    assign refCountEn = s.refEn;
    assign actCountEn = s.actEn;
    assign cstateReq = s.cst;
    assign stallCount = s.acc.cnt;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_wake;
        @(posedge mclk) disable iff (rst)
        $fell(enableArrived) |=> !forcedIdle;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Thread stayed idle after enable fell.");

    property p_blocked;
        @(posedge mclk) disable iff (rst)
        !allowBit |=> !forcedIdle;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("Blocked thread was forced idle.");

    property p_stall_on_exit;
        @(posedge mclk) disable iff (rst)
        $changed(stallCount) |-> !$past(forcedIdle) && $past(forcedIdle, 2);
    endproperty
    a_stall_on_exit: assert property (p_stall_on_exit)
        else $error("Stall count moved outside an idle exit.");

    property p_perf_counts;
        @(posedge mclk) disable iff (rst)
        forcedIdle |-> refCountEn && !actCountEn;
    endproperty
    a_perf_counts: assert property (p_perf_counts)
        else $error("Cycle counter enables wrong during forced idle.");

    property p_cstate;
        @(posedge mclk) disable iff (rst)
        forcedIdle |-> cstateReq >= fid_pkg::CST_C3;
    endproperty
    a_cstate: assert property (p_cstate)
        else $error("Forced idle thread not in C3 or deeper.");

endmodule : fid_thread

`default_nettype wire

// ---- core/fid_duty_cycling.sv ----
// Package level forced idle duty cycling with its residency counters.
// Assumes one model register request at a time, synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Package enable resets to 0; when set, allowed threads may be idled.
// - Enable falling wakes every thread idled under it.
// - Enable and allow bits take writes only with capability set.
// - One shared enable per package, writable from any thread.
// - Enable changes reach threads after a long propagation delay.
// - Each thread has an allow bit resetting to 1; clear means never idled.
// - Any blocked thread may stop duty cycling of all others.
// - Enable arriving at a thread uses its last completed allow write.
// - Per-thread stall counter, tick rate, added only after idle exit.
// - Stall counter is readable whenever capability is set.
// - Per-core counter of deep core idle with a forced thread.
// - Core counter access without capability raises a protection fault.
// - Package shallow counter of C2 time with a forced core.
// - Package deep counter of selected C-state time with forced core.
// - Deep select bits 2:0 reset 0: none, C2, C3+, C6+, C7+.
// - Package counters and config fault without capability.
// - Reference cycles keep counting in forced idle; actual cycles stop.
// - Forced idle places the thread in C3 or deeper.
module fid_duty_cycling #(
    parameter int NUM_CORES = 2,
    parameter int THREADS_PER_CORE = 2,
    parameter int PROP_CYCLES = fid_pkg::PROP_CYCLES_DEF,
    parameter int TICK_DIV = fid_pkg::TICK_DIV_DEF,
    parameter bit STOP_ALL_ON_BLOCK = 1'b1,
    localparam int NT = NUM_CORES * THREADS_PER_CORE,
    localparam int TW = (NT > 1) ? $clog2(NT) : 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic capability,
    input wire logic msrReq,
    input wire logic msrWrite,
    input wire logic [11:0] msrAddr,
    input wire logic [TW-1:0] msrThread,
    input wire logic [63:0] msrWdata,
    input wire logic dutyPhase,
    input wire logic [NT-1:0] threadActive,
    input wire logic [NUM_CORES-1:0] coreDeep,
    input wire logic [2:0] pkgCState,
    output logic msrAck,
    output logic msrFault,
    output logic [63:0] msrRdata,
    output logic [NT-1:0] forcedIdle,
    output logic [NT-1:0] refCountEn,
    output logic [NT-1:0] actCountEn,
    output logic [NT*3-1:0] cstateReq
);

    if (NUM_CORES < 1 || THREADS_PER_CORE < 1) begin : g_bad_size
        $error("Core and thread counts must be at least one.");
    end
    if (PROP_CYCLES < 1 || PROP_CYCLES > 65535) begin : g_bad_prop
        $error("Propagation delay must be 1 to 65535 cycles.");
    end
    if (TICK_DIV < 1 || TICK_DIV > 256) begin : g_bad_div
        $error("Timestamp divider must be 1 to 256.");
    end

    typedef struct packed {
        logic pkgEnable;
        logic propEnable;
        logic [15:0] propCnt;
        logic [2:0] deepSel;
        logic [7:0] tickCnt;
        logic tickPulse;
        logic ack;
        logic fault;
        logic [63:0] rdata;
        fid_pkg::fid_acc_s [NUM_CORES-1:0] core;
        fid_pkg::fid_acc_s shallow;
        fid_pkg::fid_acc_s deep;
    } fid_top_s;

    fid_top_s s;
    fid_top_s n;

    logic [NT-1:0] allowWr;
    logic [NT-1:0] allowVec;
    logic [NT-1:0] forcedVec;
    logic [NT-1:0][63:0] stallVec;
    logic holdOff;
    logic anyForced;
    logic deepMatch;
    logic [TW-1:0] coreIdx;

    ////////////////////////////////////////////////////////////////////////
    // Per-thread logic.
    for (genvar t = 0; t < NT; t++) begin : g_thread
        fid_thread u_thread (
            .mclk(mclk),
            .rst(rst),
            .stampTick(s.tickPulse),
            .allowWr(allowWr[t]),
            .allowWdata(msrWdata[fid_pkg::ALLOW_BIT]),
            .enableArrived(s.propEnable),
            .dutyPhase(dutyPhase),
            .holdOff(holdOff),
            .threadActive(threadActive[t]),
            .allowBit(allowVec[t]),
            .forcedIdle(forcedVec[t]),
            .refCountEn(refCountEn[t]),
            .actCountEn(actCountEn[t]),
            .cstateReq(cstateReq[t*3 +: 3]),
            .stallCount(stallVec[t])
        );
    end

    assign forcedIdle = forcedVec;
    assign holdOff = STOP_ALL_ON_BLOCK && !(&allowVec);
    assign anyForced = |forcedVec;
    assign coreIdx = TW'(int'(msrThread) / THREADS_PER_CORE);

    ////////////////////////////////////////////////////////////////////////
    // Deep counter state match.
    always_comb begin
        if (s.deepSel == fid_pkg::SEL_C2_ONLY) begin
            deepMatch = (pkgCState == fid_pkg::PKG_C2);
        end else if (s.deepSel == fid_pkg::SEL_NONE
                     || s.deepSel > fid_pkg::SEL_LAST) begin
            deepMatch = 1'b0;
        end else begin
            deepMatch = (pkgCState >= s.deepSel);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.
    always_comb begin
        n = s;
        allowWr = '0;
        n.ack = 1'b0;
        n.fault = 1'b0;
        n.tickPulse = (s.tickCnt == 8'(TICK_DIV - 1));
        n.tickCnt = n.tickPulse ? 8'h0 : s.tickCnt + 8'h1;

        // Enable propagates to the threads only after the delay.
        if (s.pkgEnable == s.propEnable) begin
            n.propCnt = 16'h0;
        end else if (s.propCnt == 16'(PROP_CYCLES - 1)) begin
            n.propEnable = s.pkgEnable;
            n.propCnt = 16'h0;
        end else begin
            n.propCnt = s.propCnt + 16'h1;
        end

        for (int c = 0; c < NUM_CORES; c++) begin
            n.core[c] = fid_pkg::fid_acc_step(s.core[c],
                coreDeep[c] & (|forcedVec[c*THREADS_PER_CORE +:
                THREADS_PER_CORE]), s.tickPulse);
        end
        n.shallow = fid_pkg::fid_acc_step(s.shallow,
            (pkgCState == fid_pkg::PKG_C2) & anyForced,
            s.tickPulse);
        n.deep = fid_pkg::fid_acc_step(s.deep, deepMatch & anyForced,
            s.tickPulse);

        if (msrReq) begin
            n.ack = 1'b1;
            n.rdata = 64'h0;
            unique case (msrAddr)
                fid_pkg::ADDR_PKG_ENABLE: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (msrWrite) begin
                        // Upper bits are expected zero and are dropped.
                        n.pkgEnable = msrWdata[fid_pkg::ENABLE_BIT];
                    end else begin
                        n.rdata[fid_pkg::ENABLE_BIT] = s.pkgEnable;
                    end
                end
                fid_pkg::ADDR_THREAD_ALLOW: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (msrWrite) begin
                        allowWr[msrThread] = 1'b1;
                    end else begin
                        n.rdata[fid_pkg::ALLOW_BIT] = allowVec[msrThread];
                    end
                end
                fid_pkg::ADDR_THREAD_STALL: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (!msrWrite) begin
                        n.rdata = stallVec[msrThread];
                    end
                end
                fid_pkg::ADDR_CORE_IDLE: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (!msrWrite) begin
                        n.rdata = s.core[coreIdx].cnt;
                    end
                end
                fid_pkg::ADDR_PKG_SHALLOW: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (!msrWrite) begin
                        n.rdata = s.shallow.cnt;
                    end
                end
                fid_pkg::ADDR_PKG_DEEP: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (!msrWrite) begin
                        n.rdata = s.deep.cnt;
                    end
                end
                fid_pkg::ADDR_DEEP_CONFIG: begin
                    if (!capability) begin
                        n.fault = 1'b1;
                    end else if (msrWrite) begin
                        n.deepSel = msrWdata[fid_pkg::SELECT_LSB +:
                            fid_pkg::SELECT_W];
                    end else begin
                        n.rdata[fid_pkg::SELECT_LSB +: fid_pkg::SELECT_W] =
                            s.deepSel;
                    end
                end
                default: begin
                    n.fault = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.pkgEnable <= fid_pkg::RST_PKG_ENABLE;
            s.deepSel <= fid_pkg::RST_DEEP_SELECT;
        end else begin
            s <= n;
        end
    end

    assign msrAck = s.ack;
    assign msrFault = s.fault;
    assign msrRdata = s.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_cap_write;
        @(posedge mclk) disable iff (rst)
        msrReq && msrWrite && !capability |=> $stable(s.pkgEnable)
            && msrFault;
    endproperty
    a_cap_write: assert property (p_cap_write)
        else $error("Write took effect without capability.");

    property p_pkg_write;
        @(posedge mclk) disable iff (rst)
        msrReq && msrWrite && capability
            && msrAddr == fid_pkg::ADDR_PKG_ENABLE
            |=> s.pkgEnable == $past(msrWdata[0]) && msrAck;
    endproperty
    a_pkg_write: assert property (p_pkg_write)
        else $error("Package enable write not stored.");

    property p_prop_delay;
        @(posedge mclk) disable iff (rst)
        $changed(s.propEnable) |-> $past(s.pkgEnable != s.propEnable);
    endproperty
    a_prop_delay: assert property (p_prop_delay)
        else $error("Propagated enable moved without a change.");

    property p_core_fault;
        @(posedge mclk) disable iff (rst)
        msrReq && !capability && msrAddr == fid_pkg::ADDR_CORE_IDLE
            |=> msrAck && msrFault;
    endproperty
    a_core_fault: assert property (p_core_fault)
        else $error("Core counter access did not fault.");

    property p_stall_read;
        @(posedge mclk) disable iff (rst)
        msrReq && !msrWrite && capability
            && msrAddr == fid_pkg::ADDR_THREAD_STALL
            |=> msrAck && !msrFault;
    endproperty
    a_stall_read: assert property (p_stall_read)
        else $error("Stall counter read refused.");

    property p_deep_off;
        @(posedge mclk) disable iff (rst)
        (s.deepSel == fid_pkg::SEL_NONE) [*3] |-> $stable(s.deep.cnt);
    endproperty
    a_deep_off: assert property (p_deep_off)
        else $error("Deep counter moved with counting off.");

    property p_block_all;
        @(posedge mclk) disable iff (rst)
        STOP_ALL_ON_BLOCK && !(&allowVec) |=> !anyForced;
    endproperty
    a_block_all: assert property (p_block_all)
        else $error("Duty cycling went on with a blocked thread.");

    property p_enable_off;
        @(posedge mclk) disable iff (rst)
        !s.propEnable |=> !anyForced;
    endproperty
    a_enable_off: assert property (p_enable_off)
        else $error("Thread forced idle with enable clear.");

    property p_shallow_fold;
        @(posedge mclk) disable iff (rst)
        $changed(s.shallow.cnt) |-> !s.shallow.on && $past(s.shallow.on);
    endproperty
    a_shallow_fold: assert property (p_shallow_fold)
        else $error("Shallow count moved outside a C2 exit.");

endmodule : fid_duty_cycling

`default_nettype wire

// ---- test/tb_fid_duty_cycling.sv ----
// Self-checking testbench for the forced idle duty cycling block.
// Assumes the block answers every register request with one acknowledge.
`timescale 1ns/1ps
`default_nettype none

module tb_fid_duty_cycling;

    ////////////////////////////////////////////////////////////////////////
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic capability = 1'b1;
    logic msrReq = 1'b0;
    logic msrWrite = 1'b0;
    logic [11:0] msrAddr = 12'h000;
    logic [1:0] msrThread = 2'h0;
    logic [63:0] msrWdata = 64'h0;
    logic dutyPhase = 1'b0;
    logic [3:0] threadActive = 4'hF;
    logic [1:0] coreDeep = 2'h3;
    logic [2:0] pkgCState = 3'h1;
    logic msrAck;
    logic msrFault;
    logic [63:0] msrRdata;
    logic [3:0] forcedIdle;
    logic [3:0] refCountEn;
    logic [3:0] actCountEn;
    logic [11:0] cstateReq;
    int nFail = 0;
    int cmpCount = 0;
    int cycles = 0;
    integer seed = 35;
    logic [63:0] rd;
    logic [63:0] stallExp = 64'h0;
    logic [63:0] shallowExp = 64'h0;
    logic [63:0] deepExp = 64'h0;
    logic [63:0] coreExp0 = 64'h0;
    logic [63:0] coreExp1 = 64'h0;
    logic flt;

    fid_duty_cycling #(.NUM_CORES(2), .THREADS_PER_CORE(2), .PROP_CYCLES(2))
    i_dut (.mclk(mclk), .rst(rst), .capability(capability),
        .msrReq(msrReq), .msrWrite(msrWrite), .msrAddr(msrAddr),
        .msrThread(msrThread), .msrWdata(msrWdata), .dutyPhase(dutyPhase),
        .threadActive(threadActive), .coreDeep(coreDeep),
        .pkgCState(pkgCState), .msrAck(msrAck), .msrFault(msrFault),
        .msrRdata(msrRdata), .forcedIdle(forcedIdle),
        .refCountEn(refCountEn), .actCountEn(actCountEn),
        .cstateReq(cstateReq));

    initial begin
        forever #4 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d.", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : endOfTest

    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // One register access; the answer is taken at a falling edge.
    task automatic msr(input logic wr, input logic [11:0] a,
                       input logic [1:0] t, input logic [63:0] d);
        int i;
        @(negedge mclk);
        msrReq = 1'b1;
        msrWrite = wr;
        msrAddr = a;
        msrThread = t;
        msrWdata = d;
        @(negedge mclk);
        msrReq = 1'b0;
        msrWdata = 64'($random(seed));
        i = 0;
        while (msrAck !== 1'b1 && i < 3) begin
            @(negedge mclk);
            i++;
        end
        chk("msrAck", {63'h0, msrAck}, 64'h1);
        rd = msrRdata;
        flt = msrFault;
    endtask : msr

    task automatic rdChk(input string what, input logic [11:0] a,
                         input logic [1:0] t, input logic [63:0] exp,
                         input logic ef);
        msr(1'b0, a, t, 64'h0);
        chk(what, rd, exp);
        chk("msrFault", {63'h0, flt}, {63'h0, ef});
    endtask : rdChk

    task automatic waitForced(input logic [3:0] exp, input int limit);
        int i;
        i = 0;
        while (forcedIdle !== exp && i < limit) begin
            @(negedge mclk);
            i++;
        end
        chk("forcedIdle", {60'h0, forcedIdle}, {60'h0, exp});
    endtask : waitForced

    // Deep counter match for a select code and a package level.
    function automatic logic deepHit(input logic [2:0] sel,
                                     input logic [2:0] cst);
        if (sel == 3'h1) begin
            return cst == 3'h1;
        end
        return (sel >= 3'h2 && sel <= 3'h4) && cst >= sel;
    endfunction : deepHit

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            endOfTest();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] sel;
        int m;
        int n;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        rdChk("enable", fid_pkg::ADDR_PKG_ENABLE, 2'h0, 64'h0, 1'b0);
        for (int t = 0; t < 4; t++) begin
            rdChk("allow", fid_pkg::ADDR_THREAD_ALLOW, 2'(t), 64'h1, 1'b0);
        end
        rdChk("stall", fid_pkg::ADDR_THREAD_STALL, 2'h1, 64'h0, 1'b0);
        rdChk("core", fid_pkg::ADDR_CORE_IDLE, 2'h2, 64'h0, 1'b0);
        rdChk("shallow", fid_pkg::ADDR_PKG_SHALLOW, 2'h0, 64'h0, 1'b0);
        rdChk("deep", fid_pkg::ADDR_PKG_DEEP, 2'h0, 64'h0, 1'b0);
        rdChk("config", fid_pkg::ADDR_DEEP_CONFIG, 2'h0, 64'h0, 1'b0);
        rdChk("unmapped", 12'h123, 2'h0, 64'h0, 1'b1);
        for (int c = 0; c < 8; c++) begin
            msr(1'b1, fid_pkg::ADDR_DEEP_CONFIG, 2'h0, 64'(c));
            rdChk("config", fid_pkg::ADDR_DEEP_CONFIG, 2'h1, 64'(c), 1'b0);
        end
        msr(1'b1, fid_pkg::ADDR_PKG_ENABLE, 2'h3, 64'h1);
        for (int r = 0; r < 8; r++) begin
            sel = (r == 0) ? 3'h1 : 3'($random(seed));
            msr(1'b1, fid_pkg::ADDR_DEEP_CONFIG, 2'h0, {61'h0, sel});
            pkgCState = 3'($unsigned($random(seed)) % 5);
            threadActive = 4'($random(seed)) | 4'h1;
            coreDeep = 2'($random(seed));
            dutyPhase = 1'b1;
            waitForced(4'hF, 12);
            m = 0;
            n = 5 + $unsigned($random(seed)) % 20;
            repeat (n) begin
                m += int'(forcedIdle[0] === 1'b1);
                @(negedge mclk);
            end
            chk("cstateReq", {52'h0, cstateReq}, 64'h6DB);
            chk("refCountEn", {60'h0, refCountEn}, 64'hF);
            chk("actCountEn", {60'h0, actCountEn}, 64'h0);
            dutyPhase = 1'b0;
            repeat (6) begin
                m += int'(forcedIdle[0] === 1'b1);
                @(negedge mclk);
            end
            chk("actCountEn", {60'h0, actCountEn}, {60'h0, threadActive});
            stallExp += 64'(m);
            coreExp0 += coreDeep[0] ? 64'(m) : 64'h0;
            coreExp1 += coreDeep[1] ? 64'(m) : 64'h0;
            shallowExp += (pkgCState == 3'h1) ? 64'(m) : 64'h0;
            deepExp += deepHit(sel, pkgCState) ? 64'(m) : 64'h0;
            rdChk("stall", fid_pkg::ADDR_THREAD_STALL, 2'h0, stallExp, 1'b0);
            rdChk("stall", fid_pkg::ADDR_THREAD_STALL, 2'h3, stallExp, 1'b0);
            rdChk("core", fid_pkg::ADDR_CORE_IDLE, 2'h0, coreExp0, 1'b0);
            rdChk("core", fid_pkg::ADDR_CORE_IDLE, 2'h2, coreExp1, 1'b0);
            rdChk("shallow", fid_pkg::ADDR_PKG_SHALLOW, 2'h1, shallowExp, 1'b0);
            rdChk("deep", fid_pkg::ADDR_PKG_DEEP, 2'h1, deepExp, 1'b0);
        end
        msr(1'b1, fid_pkg::ADDR_THREAD_STALL, 2'h0, 64'($random(seed)));
        rdChk("stall", fid_pkg::ADDR_THREAD_STALL, 2'h0, stallExp, 1'b0);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h1, 64'h0);
        dutyPhase = 1'b1;
        repeat (10) @(negedge mclk);
        chk("forcedIdle", {60'h0, forcedIdle}, 64'h0);
        rdChk("allow", fid_pkg::ADDR_THREAD_ALLOW, 2'h1, 64'h0, 1'b0);
        rdChk("stall", fid_pkg::ADDR_THREAD_STALL, 2'h1, stallExp, 1'b0);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h1, 64'h1);
        waitForced(4'hF, 6);
        msr(1'b1, fid_pkg::ADDR_PKG_ENABLE, 2'h2, 64'h0);
        waitForced(4'h0, 8);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h2, 64'h1);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h2, 64'h0);
        msr(1'b1, fid_pkg::ADDR_PKG_ENABLE, 2'h1, 64'h1);
        repeat (10) @(negedge mclk);
        chk("forcedIdle", {60'h0, forcedIdle}, 64'h0);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h2, 64'h1);
        waitForced(4'hF, 6);
        msr(1'b1, fid_pkg::ADDR_PKG_ENABLE, 2'h0, 64'h0);
        dutyPhase = 1'b0;
        capability = 1'b0;
        msr(1'b1, fid_pkg::ADDR_PKG_ENABLE, 2'h0, 64'h1);
        chk("msrFault", {63'h0, flt}, 64'h1);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h0, 64'h0);
        chk("msrFault", {63'h0, flt}, 64'h1);
        rdChk("core", fid_pkg::ADDR_CORE_IDLE, 2'h0, 64'h0, 1'b1);
        rdChk("shallow", fid_pkg::ADDR_PKG_SHALLOW, 2'h0, 64'h0, 1'b1);
        rdChk("config", fid_pkg::ADDR_DEEP_CONFIG, 2'h0, 64'h0, 1'b1);
        rdChk("deep", fid_pkg::ADDR_PKG_DEEP, 2'h0, 64'h0, 1'b1);
        capability = 1'b1;
        rdChk("enable", fid_pkg::ADDR_PKG_ENABLE, 2'h0, 64'h0, 1'b0);
        rdChk("allow", fid_pkg::ADDR_THREAD_ALLOW, 2'h0, 64'h1, 1'b0);
        msr(1'b1, fid_pkg::ADDR_PKG_ENABLE, 2'h1, 64'h1);
        msr(1'b1, fid_pkg::ADDR_THREAD_ALLOW, 2'h3, 64'h0);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        rdChk("enable", fid_pkg::ADDR_PKG_ENABLE, 2'h0, 64'h0, 1'b0);
        rdChk("allow", fid_pkg::ADDR_THREAD_ALLOW, 2'h3, 64'h1, 1'b0);
        rdChk("config", fid_pkg::ADDR_DEEP_CONFIG, 2'h0, 64'h0, 1'b0);
        rdChk("stall", fid_pkg::ADDR_THREAD_STALL, 2'h1, 64'h0, 1'b0);
        endOfTest();
    end

endmodule : tb_fid_duty_cycling

`default_nettype wire
